// *** rtl/udpc_counter.sv ***
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module udpc_counter #(
  parameter bit DECADE = 1'b1   // 1 decade sequence, 0 binary
) (
  input  wire logic        aclk,            // 10 MHz system clock
  input  wire logic        aresetn,         // sync reset, low active
  input  wire logic        count_clk,       // counter clock pin
  input  wire logic        count_en_n,      // count enable, low active
  input  wire logic        dir_down,        // low up, high down
  input  wire logic        preset_load_n,   // preset load, low active
  input  wire logic [3:0]  preset_data,     // parallel data
  input  wire logic [7:0]  awaddr,          // axi write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,          // axi read address
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [3:0]  count_out,       // counter state
  output logic             terminal_flag,   // terminal count
  output logic             ripple_pulse_n   // ripple clock, low active
);

  localparam logic [3:0] TOP = DECADE ? udpc_pkg::UDPC_MAX_DEC
                                      : udpc_pkg::UDPC_MAX_BIN;

  // ***************************************************
  // counter core
  // ***************************************************
  logic [3:0]  cnt_reg,   cnt_next;    // four-bit state
  logic        term_reg,  term_next;   // registered terminal decode
  logic        rip_reg,   rip_next;    // registered ripple level
  logic        clk_q_reg, clk_q_next;  // last sample of counter clock
  logic        run_reg,   run_next;    // software run gate
  logic [15:0] wrap_reg,  wrap_next;   // carry/borrow events
  logic [3:0]  step_val;               // value one step on
  logic        term_now;               // decode of present state
  logic        rise;                   // counter clock rising
  logic        step_en;                // an enabled count edge
  logic        wrap_clr;               // software clears wraps

  // step and decode of the live state
  udpc_step #(.DECADE(DECADE)) u_step (
    .cur  (cnt_reg),
    .down (dir_down),
    .nxt  (step_val),
    .term (term_now)
  );

  // decode of the value the state is about to take
  udpc_step #(.DECADE(DECADE)) u_dec (
    .cur  (cnt_next),
    .down (dir_down),
    .nxt  (),
    .term (term_next)
  );

  // edge of the pin clock, seen one aclk late
  assign rise    = count_clk & ~clk_q_reg;
  assign step_en = preset_load_n & rise & ~count_en_n & run_reg;

  // next counter state
  always_comb begin
    clk_q_next = count_clk;
    cnt_next   = cnt_reg;
    if (!preset_load_n) begin
      // preset wins over clock, enable and direction
      cnt_next = preset_data;
    end else if (step_en) begin
      cnt_next = step_val;
    end
    // a step taken from the terminal state is a carry/borrow;
    // it beats a clear in the same cycle
    if (step_en && term_now) begin
      wrap_next = 16'(wrap_reg + udpc_pkg::UDPC_WRAP_ONE);
    end else if (wrap_clr) begin
      wrap_next = udpc_pkg::UDPC_WRAP_RST;
    end else begin
      wrap_next = wrap_reg;
    end
  end

  // ripple low only while enabled, terminal, clock low; the flag
  // is registered so it cannot spike, yet must not clock logic
  assign rip_next = ~(~count_en_n & term_next & ~count_clk);

  // counter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg   <= udpc_pkg::UDPC_CNT_RST;
      term_reg  <= 1'b0;
      rip_reg   <= 1'b1;
      clk_q_reg <= 1'b1;                            // pin rests high
      wrap_reg  <= udpc_pkg::UDPC_WRAP_RST;
    end else begin
      cnt_reg   <= cnt_next;
      term_reg  <= term_next;
      rip_reg   <= rip_next;
      clk_q_reg <= clk_q_next;
      wrap_reg  <= wrap_next;
    end
  end

  assign count_out      = cnt_reg;
  assign terminal_flag  = term_reg;
  assign ripple_pulse_n = rip_reg;

  // ***************************************************
  // axi4-lite write side
  // ***************************************************
  udpc_pkg::udpc_wr_state_t wst_reg, wst_next;  // collect or answer
  logic       aw_hold_reg, aw_hold_next;        // address held
  logic       w_hold_reg,  w_hold_next;         // data held
  logic [7:0] waddr_reg,   waddr_next;          // held address
  logic [31:0] wdat_reg,   wdat_next;           // held data
  logic [3:0] wstb_reg,    wstb_next;           // held strobes
  logic       awr_reg,     awr_next;            // awready
  logic       wr_reg,      wr_next;             // wready
  logic       bv_reg,      bv_next;             // bvalid
  logic [1:0] br_reg,      br_next;             // bresp
  logic       aw_have, w_have;                  // either held or taken
  logic [7:0] wa;                               // address in use
  logic [31:0] wd;                              // data in use
  logic [3:0] ws;                               // strobes in use
  logic       do_write;                         // both halves present

  // address and data may arrive in either order
  always_comb begin
    aw_have  = aw_hold_reg | (awvalid & awr_reg);
    w_have   = w_hold_reg  | (wvalid  & wr_reg);
    wa       = aw_hold_reg ? waddr_reg : awaddr;
    wd       = w_hold_reg  ? wdat_reg  : wdata;
    ws       = w_hold_reg  ? wstb_reg  : wstrb;
    do_write = (wst_reg == udpc_pkg::wr_collect) & aw_have & w_have;
    waddr_next   = (awvalid & awr_reg) ? awaddr : waddr_reg;
    wdat_next    = (wvalid & wr_reg)   ? wdata  : wdat_reg;
    wstb_next    = (wvalid & wr_reg)   ? wstrb  : wstb_reg;
    aw_hold_next = aw_have & ~do_write;
    w_hold_next  = w_have  & ~do_write;
    run_next     = run_reg;
    wrap_clr     = 1'b0;
    br_next      = br_reg;
    wst_next     = wst_reg;
    bv_next      = bv_reg;
    case (wst_reg)
      udpc_pkg::wr_collect: begin
        if (do_write) begin
          wst_next = udpc_pkg::wr_resp;
          bv_next  = 1'b1;
          br_next  = udpc_pkg::UDPC_OKAY;
          if (wa == udpc_pkg::UDPC_CTRL_OFS) begin
            // run gate lives in byte lane 0
            if (ws[0]) begin
              run_next = wd[udpc_pkg::UDPC_RUN_BIT];
            end
          end else if (wa == udpc_pkg::UDPC_WRAP_OFS) begin
            wrap_clr = 1'b1;                        // any write clears unless a carry/borrow is counted in the same cycle
          end else if (wa != udpc_pkg::UDPC_STAT_OFS) begin
            br_next = udpc_pkg::UDPC_SLVERR;        // unmapped
          end
        end
      end
      udpc_pkg::wr_resp: begin
        if (bready) begin
          wst_next = udpc_pkg::wr_collect;
          bv_next  = 1'b0;
        end
      end
      default: begin
        wst_next = udpc_pkg::wr_collect;
        bv_next  = 1'b0;
      end
    endcase
    // each ready drops while its half is held or an answer is out
    awr_next = ~aw_hold_next & (wst_next == udpc_pkg::wr_collect);
    wr_next  = ~w_hold_next  & (wst_next == udpc_pkg::wr_collect);
  end

  // write side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg     <= udpc_pkg::wr_collect;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdat_reg    <= udpc_pkg::UDPC_DATA_ZERO;
      wstb_reg    <= 4'h0;
      awr_reg     <= 1'b0;
      wr_reg      <= 1'b0;
      bv_reg      <= 1'b0;
      br_reg      <= udpc_pkg::UDPC_OKAY;
      run_reg     <= udpc_pkg::UDPC_RUN_RST;
    end else begin
      wst_reg     <= wst_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      waddr_reg   <= waddr_next;
      wdat_reg    <= wdat_next;
      wstb_reg    <= wstb_next;
      awr_reg     <= awr_next;
      wr_reg      <= wr_next;
      bv_reg      <= bv_next;
      br_reg      <= br_next;
      run_reg     <= run_next;
    end
  end

  assign awready = awr_reg;
  assign wready  = wr_reg;
  assign bvalid  = bv_reg;
  assign bresp   = br_reg;

  // ***************************************************
  // axi4-lite read side
  // ***************************************************
  udpc_pkg::udpc_rd_state_t rst_reg, rst_next;  // idle or answering
  logic        arr_reg, arr_next;               // arready
  logic        rv_reg,  rv_next;                // rvalid
  logic [31:0] rd_reg,  rd_next;                // rdata
  logic [1:0]  rr_reg,  rr_next;                // rresp
  udpc_pkg::udpc_stat_t stat;                   // live status word

  // status is sampled at the address handshake
  always_comb begin
    stat.preset_act = ~preset_load_n;
    stat.dir_down   = dir_down;
    stat.ripple_n   = rip_reg;
    stat.terminal   = term_reg;
    stat.count      = cnt_reg;
    rst_next = rst_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    case (rst_reg)
      udpc_pkg::rd_idle: begin
        if (arvalid && arr_reg) begin
          rst_next = udpc_pkg::rd_data;
          rv_next  = 1'b1;
          rr_next  = udpc_pkg::UDPC_OKAY;
          if (araddr == udpc_pkg::UDPC_CTRL_OFS) begin
            rd_next = {udpc_pkg::UDPC_CTRL_HI, run_reg};
          end else if (araddr == udpc_pkg::UDPC_STAT_OFS) begin
            rd_next = {udpc_pkg::UDPC_STAT_HI, stat};
          end else if (araddr == udpc_pkg::UDPC_WRAP_OFS) begin
            rd_next = {udpc_pkg::UDPC_STAT_PAD, wrap_reg};
          end else begin
            rd_next = udpc_pkg::UDPC_DATA_ZERO;
            rr_next = udpc_pkg::UDPC_SLVERR;
          end
        end
      end
      udpc_pkg::rd_data: begin
        if (rready) begin
          rst_next = udpc_pkg::rd_idle;
          rv_next  = 1'b0;
        end
      end
      default: begin
        rst_next = udpc_pkg::rd_idle;
        rv_next  = 1'b0;
      end
    endcase
    arr_next = (rst_next == udpc_pkg::rd_idle);
  end

  // read side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_reg <= udpc_pkg::rd_idle;
      arr_reg <= 1'b0;
      rv_reg  <= 1'b0;
      rd_reg  <= udpc_pkg::UDPC_DATA_ZERO;
      rr_reg  <= udpc_pkg::UDPC_OKAY;
    end else begin
      rst_reg <= rst_next;
      arr_reg <= arr_next;
      rv_reg  <= rv_next;
      rd_reg  <= rd_next;
      rr_reg  <= rr_next;
    end
  end

  assign arready = arr_reg;
  assign rvalid  = rv_reg;
  assign rdata   = rd_reg;
  assign rresp   = rr_reg;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_step;
    preset_load_n && rise && !count_en_n && run_reg;
  endsequence

  sequence s_idle_edge;
    preset_load_n && !(rise && !count_en_n && run_reg);
  endsequence

  property p_no_step;
    s_idle_edge |=> $stable(count_out);
  endproperty
  a_no_step: assert property (p_no_step)
    else $error("state moved without an enabled edge");
  property p_hold;
    preset_load_n && count_en_n |=> count_out == $past(count_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved while count enable high");
  property p_preset;
    !preset_load_n |=> count_out == $past(preset_data);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset data not loaded");

  property p_up;
    s_step ##0 (!dir_down && count_out < TOP)
      |=> count_out == 4'($past(count_out) + udpc_pkg::UDPC_ONE);
  endproperty
  a_up: assert property (p_up)
    else $error("up count did not increment");
  property p_down;
    s_step ##0 (dir_down && count_out != udpc_pkg::UDPC_ZERO)
      |=> count_out == 4'($past(count_out) - udpc_pkg::UDPC_ONE);
  endproperty
  a_down: assert property (p_down)
    else $error("down count did not decrement");
  property p_wrap;
    s_step ##0 (dir_down && count_out == udpc_pkg::UDPC_ZERO)
      |=> count_out == TOP;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("down count did not wrap to top");
  property p_term;
    $past(aresetn) && $stable(dir_down) |-> terminal_flag ==
      (dir_down ? count_out == udpc_pkg::UDPC_ZERO : count_out == TOP);
  endproperty
  a_term: assert property (p_term)
    else $error("terminal flag disagrees with state");
  property p_decade;
    count_out <= TOP && preset_load_n |=> count_out <= TOP;
  endproperty
  a_decade: assert property (p_decade)
    else $error("count left its sequence");
  property p_rip_low;
    !count_en_n && !count_clk |=> ripple_pulse_n == !terminal_flag;
  endproperty
  a_rip_low: assert property (p_rip_low)
    else $error("ripple pulse wrong while clock low");

  property p_rip_high;
    count_en_n || count_clk |=> ripple_pulse_n;
  endproperty
  a_rip_high: assert property (p_rip_high)
    else $error("ripple pulse low while inhibited");

endmodule : udpc_counter

// *** rtl/udpc_pkg.sv ***
package udpc_pkg;

  // ***************************************************
  // counter geometry
  // ***************************************************
  localparam int unsigned UDPC_CNT_W   = 4;      // state width
  localparam logic [3:0]  UDPC_MAX_DEC = 4'h9;   // decade top
  localparam logic [3:0]  UDPC_MAX_BIN = 4'hF;   // binary top
  localparam logic [3:0]  UDPC_ZERO    = 4'h0;   // bottom
  localparam logic [3:0]  UDPC_ONE     = 4'h1;   // step size
  localparam logic [3:0]  UDPC_CNT_RST = 4'h0;   // state at reset

  // ***************************************************
  // register map
  // ***************************************************
  localparam int unsigned UDPC_ADDR_W   = 8;     // byte address bits
  localparam logic [7:0]  UDPC_CTRL_OFS = 8'h00; // control
  localparam logic [7:0]  UDPC_STAT_OFS = 8'h04; // live status
  localparam logic [7:0]  UDPC_WRAP_OFS = 8'h08; // wrap events
  localparam int unsigned UDPC_RUN_BIT  = 0;     // run gate in control
  localparam logic        UDPC_RUN_RST  = 1'b1;  // counting allowed
  localparam int unsigned UDPC_WRAP_W   = 16;    // wrap counter width
  localparam logic [15:0] UDPC_WRAP_RST = 16'h0000;
  localparam logic [15:0] UDPC_WRAP_ONE = 16'h0001;
  localparam logic [15:0] UDPC_STAT_PAD = 16'h0000;
  localparam logic [23:0] UDPC_STAT_HI  = 24'h000000;
  localparam logic [30:0] UDPC_CTRL_HI  = 31'h00000000;
  localparam logic [31:0] UDPC_DATA_ZERO = 32'h00000000;
  localparam logic [1:0]  UDPC_OKAY     = 2'h0;  // axi okay
  localparam logic [1:0]  UDPC_SLVERR   = 2'h2;  // axi slave error

  // ***************************************************
  // carriers and states
  // ***************************************************
  typedef struct packed {
    logic       preset_act;  // preset load held low
    logic       dir_down;    // counting direction
    logic       ripple_n;    // ripple output level
    logic       terminal;    // terminal flag level
    logic [3:0] count;       // present state
  } udpc_stat_t;

  typedef enum {rd_idle, rd_data}  udpc_rd_state_t;
  typedef enum {wr_collect, wr_resp} udpc_wr_state_t;

endpackage : udpc_pkg

// *** rtl/udpc_step.sv ***
`timescale 1ns/10ps
// ***************************************************
// next count value and terminal decode of one state
// ***************************************************
module udpc_step #(
  parameter bit DECADE = 1'b1   // 1 decade, 0 binary
) (
  input  wire logic [3:0] cur,   // state to examine
  input  wire logic       down,  // direction, high counts down
  output logic      [3:0] nxt,   // state after one step
  output logic            term   // terminal decode of cur
);

  localparam logic [3:0] TOP = DECADE ? udpc_pkg::UDPC_MAX_DEC
                                      : udpc_pkg::UDPC_MAX_BIN;

  // step with wrap at both ends
  always_comb begin
    if (down) begin
      if (cur == udpc_pkg::UDPC_ZERO) begin
        nxt = TOP;
      end else begin
        nxt = cur - udpc_pkg::UDPC_ONE;
      end
    end else begin
      // values above the top after a preset also fold to zero
      if (cur >= TOP) begin
        nxt = udpc_pkg::UDPC_ZERO;
      end else begin
        nxt = cur + udpc_pkg::UDPC_ONE;
      end
    end
  end

  // pure state and direction decode, no enable term
  always_comb begin
    term = down ? (cur == udpc_pkg::UDPC_ZERO)
                : (cur == TOP);
  end

endmodule : udpc_step

// *** verification/udpc_ctl_model.sv ***
`timescale 1ns/10ps
// ****
// far-side control logic driving one counter stage
// ****
module udpc_ctl_model (
  input  wire logic       aclk,          // system clock
  output logic            count_clk,     // counter clock, rests high
  output logic            count_en_n,    // count enable, low active
  output logic            dir_down,      // low up, high down
  output logic            preset_load_n, // preset load, low active
  output logic      [3:0] preset_data    // parallel data
);
  // pins at time zero; the clock rests high between pulses
  initial begin
    count_clk     = 1'b1;
    count_en_n    = 1'b0;
    dir_down      = 1'b0;
    preset_load_n = 1'b1;
    preset_data   = 4'h0;
  end

  // low phase of lo cycles, plus margin for the ripple output
  task clk_low(input int lo);
    @(posedge aclk);
    count_clk <= 1'b0;
    repeat (lo + 2) @(posedge aclk);
  endtask : clk_low

  // rising edge, then let state and flags settle
  task clk_high();
    @(posedge aclk);
    count_clk <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : clk_high

  // one count pulse; lo sets how slow the far side is
  task pulse(input int lo);
    clk_low(lo);
    clk_high();
  endtask : pulse

  // enable only moves while the clock rests high
  task set_en(input logic v);
    @(posedge aclk);
    count_en_n <= v;
    @(posedge aclk);
  endtask : set_en

  // direction only moves while the clock rests high
  task set_dir(input logic v);
    @(posedge aclk);
    dir_down <= v;
    repeat (2) @(posedge aclk);
  endtask : set_dir

  // data is scrambled after the load so stale data is never relied on
  task preset(input logic [3:0] v);
    @(posedge aclk);
    preset_data   <= v;
    preset_load_n <= 1'b0;
    repeat (2) @(posedge aclk);
    preset_load_n <= 1'b1;
    preset_data   <= ~v;
    repeat (2) @(posedge aclk);
  endtask : preset
  // the terminal flag is never used as a clock here
  // single stage only; cascade wiring is left to callers
endmodule : udpc_ctl_model

// *** verification/tb_updown_preset_counter.sv ***
`timescale 1ns/10ps
module tb_updown_preset_counter;
  // ****
  // signals
  // ****
  logic        aclk, aresetn, count_clk, count_en_n, dir_down;
  logic        preset_load_n, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        awready_b, wready_b, bvalid_b, arready_b, rvalid_b;
  logic [3:0]  preset_data, wstrb, count_out, cnt_bin, ed, eb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdata_b;
  logic [1:0]  bresp, rresp, bresp_b, rresp_b;
  logic        terminal_flag, term_bin, ripple_pulse_n, rip_bin, dn;
  int          n_mismatch, checks_done;

  // ****
  // design, binary twin and far side
  // ****
  udpc_counter #(.DECADE(1'b1)) i_udpc_counter (
    .aclk(aclk), .aresetn(aresetn), .count_clk(count_clk),
    .count_en_n(count_en_n), .dir_down(dir_down),
    .preset_load_n(preset_load_n), .preset_data(preset_data),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .count_out(count_out), .terminal_flag(terminal_flag),
    .ripple_pulse_n(ripple_pulse_n));
  // shares every input; its bus answers are checked as well
  udpc_counter #(.DECADE(1'b0)) i_udpc_counter_bin (
    .aclk(aclk), .aresetn(aresetn), .count_clk(count_clk),
    .count_en_n(count_en_n), .dir_down(dir_down),
    .preset_load_n(preset_load_n), .preset_data(preset_data),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready_b),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready_b),
    .bresp(bresp_b), .bvalid(bvalid_b), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready_b),
    .rdata(rdata_b), .rresp(rresp_b), .rvalid(rvalid_b), .rready(rready),
    .count_out(cnt_bin), .terminal_flag(term_bin),
    .ripple_pulse_n(rip_bin));
  udpc_ctl_model i_udpc_ctl_model (
    .aclk(aclk), .count_clk(count_clk), .count_en_n(count_en_n),
    .dir_down(dir_down), .preset_load_n(preset_load_n),
    .preset_data(preset_data));

  // 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ****
  // reference model and checks
  // ****
  function automatic logic [3:0] nxt(input logic [3:0] v, input logic d,
                                     input logic [3:0] mx);
    if (d) return (v == 4'h0) ? mx : v - 4'h1;
    return (v >= mx) ? 4'h0 : v + 4'h1;
  endfunction : nxt

  function automatic logic tmx(input logic [3:0] v, input logic d,
                               input logic [3:0] mx);
    return d ? (v == 4'h0) : (v == mx);
  endfunction : tmx

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // both variants against the reference state
  task chk_state();
    check(32'(count_out), 32'(ed));
    check(32'(cnt_bin), 32'(eb));
    check(32'(terminal_flag), 32'(tmx(ed, dn, udpc_pkg::UDPC_MAX_DEC)));
    check(32'(term_bin), 32'(tmx(eb, dn, udpc_pkg::UDPC_MAX_BIN)));
  endtask : chk_state

  task steps(input int n, input int lo);
    repeat (n) begin
      i_udpc_ctl_model.pulse(lo);
      ed = nxt(ed, dn, udpc_pkg::UDPC_MAX_DEC);
      eb = nxt(eb, dn, udpc_pkg::UDPC_MAX_BIN);
      chk_state();
    end
  endtask : steps

  // ****
  // register bus master
  // ****
  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 input logic [3:0] s, input logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) begin
      n_mismatch++;
      final_report();
    end
    bready <= 1'b0;
    check(32'(bresp), 32'(r));
    check(32'(bresp_b), 32'(r));
    check(32'({awready, wready, bvalid}), 32'h00000001);
    check(32'({awready_b, wready_b, bvalid_b}), 32'h00000001);
  endtask : axi_write

  task axi_read(input logic [7:0] a, input logic [31:0] d,
                input logic [31:0] db, input logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) begin
      n_mismatch++;
      final_report();
    end
    rready <= 1'b0;
    check(rdata, d);
    check(rdata_b, db);
    check(32'(rresp), 32'(r));
    check(32'(rresp_b), 32'(r));
    check(32'({arready, rvalid, arready_b, rvalid_b}), 32'h00000005);
  endtask : axi_read

  // ****
  // main sequence
  // ****
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    n_mismatch = 0;
    checks_done = 0;
    {ed, eb, dn} = 9'h000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(ripple_pulse_n), 32'h00000001);
    chk_state();
    axi_read(udpc_pkg::UDPC_CTRL_OFS, 32'h00000001, 32'h00000001, 2'h0);
    axi_write(udpc_pkg::UDPC_STAT_OFS, 32'hFFFFFFFF, 4'hF, 2'h0);
    axi_read(udpc_pkg::UDPC_STAT_OFS, 32'h00000020, 32'h00000020, 2'h0);
    axi_read(8'h0C, 32'h00000000, 32'h00000000, 2'h2);
    axi_read(8'h01, 32'h00000000, 32'h00000000, 2'h2);
    axi_write(8'h0C, 32'hFFFFFFFF, 4'hF, 2'h2);
    steps(12, 1);
    dn = 1'b1;
    i_udpc_ctl_model.set_dir(1'b1);
    chk_state();
    steps(14, 3);
    axi_read(udpc_pkg::UDPC_WRAP_OFS, 32'h00000003, 32'h00000001, 2'h0);
    axi_write(udpc_pkg::UDPC_WRAP_OFS, 32'h00000000, 4'hF, 2'h0);
    axi_read(udpc_pkg::UDPC_WRAP_OFS, 32'h00000000, 32'h00000000, 2'h0);
    dn = 1'b0;
    i_udpc_ctl_model.set_dir(1'b0);
    i_udpc_ctl_model.set_en(1'b1);
    i_udpc_ctl_model.preset(4'h9);
    ed = 4'h9;
    eb = 4'h9;
    chk_state();
    i_udpc_ctl_model.clk_low(1);
    check(32'(ripple_pulse_n), 32'h00000001);
    i_udpc_ctl_model.clk_high();
    chk_state();
    i_udpc_ctl_model.set_en(1'b0);
    i_udpc_ctl_model.clk_low(2);
    check(32'(ripple_pulse_n), 32'h00000000);
    check(32'(rip_bin), 32'h00000001);
    i_udpc_ctl_model.clk_high();
    check(32'(ripple_pulse_n), 32'h00000001);
    ed = 4'h0;
    eb = 4'hA;
    chk_state();
    // a write without byte lane 0 leaves the run gate alone
    axi_write(udpc_pkg::UDPC_CTRL_OFS, 32'h00000000, 4'hE, 2'h0);
    axi_read(udpc_pkg::UDPC_CTRL_OFS, 32'h00000001, 32'h00000001, 2'h0);
    axi_write(udpc_pkg::UDPC_CTRL_OFS, 32'h00000000, 4'hF, 2'h0);
    axi_read(udpc_pkg::UDPC_CTRL_OFS, 32'h00000000, 32'h00000000, 2'h0);
    i_udpc_ctl_model.pulse(1);
    chk_state();
    axi_write(udpc_pkg::UDPC_CTRL_OFS, 32'h00000001, 4'hF, 2'h0);
    steps(1, 1);
    i_udpc_ctl_model.preset(4'h0);
    {ed, eb} = 8'h00;
    chk_state();
    dn = 1'b1;
    i_udpc_ctl_model.set_dir(1'b1);
    chk_state();
    axi_read(udpc_pkg::UDPC_STAT_OFS, 32'h00000070, 32'h00000070, 2'h0);
    final_report();
  end
endmodule : tb_updown_preset_counter
